// *** acp_params.svh ***
// timing constants and fixed values for the conversion and power-down control block
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

`define ACP_CLK_HZ 20000000
`define ACP_CONV_TIME_NS 4000
`define ACP_LOW_POWER_SELECT_N_WAKE_US 100
`define ACP_SHDN_WAKE_US 13000
// conversion time and wake times all round down (integer division, shortest time)
`define ACP_CONV_CYCLES ((`ACP_CONV_TIME_NS * (`ACP_CLK_HZ / 1000000)) / 1000)
`define ACP_LOW_POWER_SELECT_N_CYCLES (`ACP_LOW_POWER_SELECT_N_WAKE_US * (`ACP_CLK_HZ / 1000000))
`define ACP_SHDN_CYCLES (`ACP_SHDN_WAKE_US * (`ACP_CLK_HZ / 1000000))
`define ACP_CHANNELS 8
`define ACP_SAMPLE_W 18
`define ACP_GROUP_MASK1 8'h0f
`define ACP_GROUP_MASK2 8'hf0

`endif

// *** acp_pkg.sv ***
// types shared by the conversion and power-down control block
`default_nettype none
package acp_pkg;
    typedef enum logic [1:0] {
        ACP_PWR_NORMAL,
        ACP_PWR_STANDBY,
        ACP_PWR_SHUTDOWN
    } acp_pwr_e;
    typedef enum logic [2:0] {
        ACP_ST_OFF,
        ACP_ST_WAKE,
        ACP_ST_NEED_RESET,
        ACP_ST_IDLE,
        ACP_ST_CONVERT
    } acp_state_e;
endpackage
`default_nettype wire

// *** acp_ctrl.sv ***
// conversion start, busy timing and power-down control of an 8-channel sampling converter
// Summary of operation
// R1 - standby select low: range picks standby/shutdown
// R2 - standby keeps reference, wakes in 100 us
// R3 - shutdown powers all off, wakes 13 ms
// R4 - host resets after shutdown wake time
// R5 - host resets once supplies come up
// R6 - common start edge holds all channels
// R7 - busy high from start until all converted
// R8 - busy fall returns all holds to track
// R9 - results offered after busy falls
// R10 - first start edge holds channels 1-4
// R11 - second start edge holds channels 5-8
// R12 - split starts: busy on later edge
// R13 - split starts only without oversampling
// R14 - all channels converted, same read order
// R15 - conversion lasts 4 us to busy fall
// R16 - old results readable while busy high
// R17 - host avoids starts when busy or down
`include "acp_params.svh"
`default_nettype none
module acp_ctrl
    import acp_pkg::*;
#(
    parameter int CONV_CYCLES = `ACP_CONV_CYCLES,
    parameter int LOW_POWER_SELECT_N_CYCLES = `ACP_LOW_POWER_SELECT_N_CYCLES,
    parameter int SHDN_CYCLES = `ACP_SHDN_CYCLES,
    parameter int CH = `ACP_CHANNELS,
    parameter int SW = `ACP_SAMPLE_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // conversion control pins
    input wire logic convert_start_group1,
    input wire logic convert_start_group2,
    // power control pins
    input wire logic low_power_select_n,
    input wire logic range_select,
    // converted samples from the analog core, one word per channel
    input wire logic [CH*SW-1:0] core_sample,
    // status toward the host
    output logic busy,
    output logic ready,
    output logic [1:0] power_mode,
    // per-channel hold controls toward the analog front end
    output logic [CH-1:0] hold,
    // analog block enables
    output logic ref_enable,
    output logic amp_enable,
    // output register feeding the readout interfaces
    output logic [CH*SW-1:0] result,
    output logic result_valid
);
    // one timer serves conversion and both wake-ups, so it must fit the longest of them
    localparam int WAKE_MAX = (SHDN_CYCLES > LOW_POWER_SELECT_N_CYCLES) ? SHDN_CYCLES : LOW_POWER_SELECT_N_CYCLES;
    localparam int CNT_MAX = (WAKE_MAX > CONV_CYCLES) ? WAKE_MAX : CONV_CYCLES;
    localparam int CW = $clog2(CNT_MAX + 1);

    logic start1_q; // previous level of start group 1
    logic start2_q; // previous level of start group 2
    logic rise1;
    logic rise2;
    logic armed1; // group 1 sampled, waiting for group 2
    logic armed2;
    acp_state_e state;
    logic [CW-1:0] count; // shared timer for conversion and wake-up
    logic rst_q; // reset seen last cycle

    // true when the edge of either group completes the pair
    function automatic logic pair_done(input logic r1, input logic r2,
                                       input logic a1, input logic a2);
        pair_done = (r1 || a1) && (r2 || a2);
    endfunction

    // current power request decoded from the pins
    function automatic acp_pwr_e pwr_req(input logic sel_n, input logic rng);
        if (sel_n) begin
            pwr_req = ACP_PWR_NORMAL;
        end else if (rng) begin
            pwr_req = ACP_PWR_STANDBY; // R1
        end else begin
            pwr_req = ACP_PWR_SHUTDOWN; // R1
        end
    endfunction

    assign rise1 = convert_start_group1 && !start1_q;
    assign rise2 = convert_start_group2 && !start2_q;

    // edge detect registers for the start pins
    always_ff @(posedge clock) begin
        if (rst) begin
            start1_q <= 1'b0;
            start2_q <= 1'b0;
        end else begin
            start1_q <= convert_start_group1;
            start2_q <= convert_start_group2;
        end
    end

    // power and conversion sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ACP_ST_IDLE;
            count <= '0;
            power_mode <= 2'(ACP_PWR_NORMAL);
            rst_q <= 1'b1;
        end else begin
            rst_q <= 1'b0;
            case (state)
                ACP_ST_IDLE: begin
                    if (pwr_req(low_power_select_n, range_select) != ACP_PWR_NORMAL) begin
                        state <= ACP_ST_OFF;
                        power_mode <= 2'(pwr_req(low_power_select_n, range_select)); // R1
                    end else if (pair_done(rise1, rise2, armed1, armed2)) begin
                        state <= ACP_ST_CONVERT; // R6 R12
                        count <= CW'(CONV_CYCLES - 1);
                    end
                end
                ACP_ST_CONVERT: begin
                    // a conversion runs to its end even if power-down is asked meanwhile
                    if (count == '0) begin
                        state <= ACP_ST_IDLE; // R15
                    end else begin
                        count <= count - 1'b1; // R7
                    end
                end
                ACP_ST_OFF: begin
                    if (low_power_select_n) begin
                        state <= ACP_ST_WAKE;
                        count <= (power_mode == 2'(ACP_PWR_SHUTDOWN)) ?
                                 CW'(SHDN_CYCLES - 1) : CW'(LOW_POWER_SELECT_N_CYCLES - 1); // R2 R3
                    end
                end
                ACP_ST_WAKE: begin
                    if (!low_power_select_n) begin
                        state <= ACP_ST_OFF; // dropped back before waking
                    end else if (count == '0) begin
                        // shutdown loses configuration, so a reset is needed
                        state <= (power_mode == 2'(ACP_PWR_SHUTDOWN)) ?
                                 ACP_ST_NEED_RESET : ACP_ST_IDLE; // R4
                        if (power_mode != 2'(ACP_PWR_SHUTDOWN)) begin
                            power_mode <= 2'(ACP_PWR_NORMAL);
                        end
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ACP_ST_NEED_RESET: begin
                    // only the rst input or low_power_select_n going low leaves this state
                    if (!low_power_select_n) begin
                        state <= ACP_ST_OFF;
                    end
                end
                default: begin
                    state <= ACP_ST_IDLE;
                end
            endcase
        end
    end

    // split-start bookkeeping; cleared when conversion begins or power drops
    always_ff @(posedge clock) begin
        if (rst) begin
            armed1 <= 1'b0;
            armed2 <= 1'b0;
        end else if (state != ACP_ST_IDLE || !low_power_select_n) begin
            armed1 <= 1'b0; // R17
            armed2 <= 1'b0;
        end else if (pair_done(rise1, rise2, armed1, armed2)) begin
            armed1 <= 1'b0;
            armed2 <= 1'b0;
        end else begin
            armed1 <= armed1 || rise1; // R10
            armed2 <= armed2 || rise2; // R11
        end
    end

    // hold controls: each group holds on its own edge, all track after busy
    always_ff @(posedge clock) begin
        if (rst) begin
            hold <= '0;
        end else if (state == ACP_ST_CONVERT && count == '0) begin
            hold <= '0; // R8
        end else if (state == ACP_ST_IDLE && !low_power_select_n) begin
            // a half-armed group must not keep a stale sample across power-down
            hold <= '0;
        end else if (state == ACP_ST_IDLE && low_power_select_n) begin
            if (rise1) begin
                hold <= hold | CH'(`ACP_GROUP_MASK1); // R10 R6
            end
            if (rise2) begin
                hold <= hold | CH'(`ACP_GROUP_MASK2) | (rise1 ? CH'(`ACP_GROUP_MASK1) : '0); // R11
            end
        end
    end

    // busy changes on the same edges as the conversion state, rising at the edge that samples the start edge
    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state == ACP_ST_IDLE && low_power_select_n &&
                     pair_done(rise1, rise2, armed1, armed2)) ||
                    (state == ACP_ST_CONVERT && count != '0); // R7 R12
        end
    end

    // output register keeps old results during conversion, loads all at the end
    always_ff @(posedge clock) begin
        if (rst) begin
            result <= '0;
            result_valid <= 1'b0;
        end else if (state == ACP_ST_CONVERT && count == '0) begin
            result <= core_sample; // R9 R14
            result_valid <= 1'b1;
        end else if (state == ACP_ST_OFF && power_mode == 2'(ACP_PWR_SHUTDOWN)) begin
            result <= '0; // contents lost in shutdown
            result_valid <= 1'b0;
        end
        // otherwise held, readable while busy is high: R16
    end

    // analog enables and ready flag
    always_ff @(posedge clock) begin
        if (rst) begin
            ref_enable <= 1'b1;
            amp_enable <= 1'b1;
            ready <= 1'b0;
        end else begin
            ref_enable <= !(state inside {ACP_ST_OFF, ACP_ST_WAKE} &&
                            power_mode == 2'(ACP_PWR_SHUTDOWN)); // R3 R2
            amp_enable <= !(state inside {ACP_ST_OFF, ACP_ST_WAKE}); // R2
            ready <= (state == ACP_ST_IDLE) && !rst_q && low_power_select_n;
        end
    end
endmodule
`default_nettype wire

// *** acp_ctrl_props.sv ***
// assertion checker for the conversion and power-down control block
`default_nettype none
module acp_ctrl_props
    import acp_pkg::*;
#(
    parameter int CONV_CYCLES = 80,
    parameter int CH = 8,
    parameter int SW = 18
) (
    // clock, reset, pins from the host and samples from the core
    input wire logic clock,
    input wire logic rst,
    input wire logic convert_start_group1,
    input wire logic convert_start_group2,
    input wire logic low_power_select_n,
    input wire logic range_select,
    input wire logic [CH*SW-1:0] core_sample,
    // outputs under watch
    input wire logic busy,
    input wire logic ready,
    input wire logic [1:0] power_mode,
    input wire logic [CH-1:0] hold,
    input wire logic ref_enable,
    input wire logic amp_enable,
    input wire logic [CH*SW-1:0] result,
    input wire logic result_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // length of the current busy run; a counter, since 80 cycles is too long to unroll
    int busy_run;
    always_ff @(posedge clock) begin
        busy_run <= (busy && !rst) ? busy_run + 1 : 0;
    end
    conv_length_a: assert property ($fell(busy) |-> busy_run == CONV_CYCLES)
        else $error("busy run length wrong");
    track_return_a: assert property ($fell(busy) |-> hold == '0 && result_valid)
        else $error("holds not released at end");
    result_load_a: assert property ($fell(busy) |-> result == $past(core_sample))
        else $error("result not loaded at end");
    old_result_a: assert property (busy |-> $stable(result))
        else $error("result moved during busy");
    first_group_a: assert property ($rose(convert_start_group1) && ready |-> ##2 &hold[3:0])
        else $error("first group not held");
    second_group_a: assert property ($rose(convert_start_group2) && ready |-> ##2 &hold[7:4])
        else $error("second group not held");
    busy_pair_a: assert property ($rose(busy) |-> &hold)
        else $error("busy rose before both groups held");
    shut_down_a: assert property ($fell(low_power_select_n) && ready && !range_select
        |-> ##2 power_mode == ACP_PWR_SHUTDOWN ##1 !ref_enable && !amp_enable)
        else $error("shutdown not entered");
    stand_by_a: assert property ($fell(low_power_select_n) && ready && range_select
        |-> ##2 power_mode == ACP_PWR_STANDBY ##1 ref_enable && !amp_enable)
        else $error("standby not entered");
    // main scenarios reached
    cover property ($fell(busy));
    cover property (power_mode == ACP_PWR_SHUTDOWN);
    cover property (hold == 8'h0f && !busy);
endmodule
`default_nettype wire

// *** acp_host.sv ***
// host-side driver for the convert-start and power pins
`default_nettype none
module acp_host (
    // clock from the bench
    input wire logic clock,
    // pins toward the block
    output logic convert_start_group1,
    output logic convert_start_group2,
    output logic low_power_select_n,
    output logic range_select
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle pins: starts low, normal power
    initial begin
        {convert_start_group2, convert_start_group1} = 2'h0;
        {low_power_select_n, range_select} = 2'h3;
    end
    // one-cycle start pulse; split pulses only as no oversampling exists here
    task automatic start(input logic [1:0] g);
        @(negedge clock);
        {convert_start_group2, convert_start_group1} = g;
        @(negedge clock);
        {convert_start_group2, convert_start_group1} = 2'h0;
    endtask
    // power pin levels, changed off the sampling edge
    task automatic power(input logic sel_n, input logic rng);
        @(negedge clock);
        low_power_select_n = sel_n;
        range_select = rng;
    endtask
endmodule
`default_nettype wire

// *** acp_ctrl_test.sv ***
// self-checking bench for the conversion and power-down control block
`default_nettype none
module acp_ctrl_test
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 80;
    logic clock = 0, rst = 1, g1, g2, sel_n, rng, busy, ready, ref_enable, amp_enable;
    logic result_valid;
    logic [1:0] power_mode;
    logic [7:0] hold;
    logic [143:0] core_sample = '0, result;
    int fail_count = 0, comparisons = 0, blen = 0, cycles = 0;
    always #25 clock = ~clock;
    // busy length seen from outside
    always @(negedge clock) if (busy === 1'b1) blen++;
    // hang guard, far above the few hundred cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop;
        end
    end
    acp_host host (.clock(clock), .convert_start_group1(g1), .convert_start_group2(g2),
        .low_power_select_n(sel_n), .range_select(rng));
    acp_ctrl #(.CONV_CYCLES(CONV), .LOW_POWER_SELECT_N_CYCLES(10), .SHDN_CYCLES(20)) DUT (.clock(clock),
        .rst(rst), .convert_start_group1(g1), .convert_start_group2(g2),
        .low_power_select_n(sel_n), .range_select(rng), .core_sample(core_sample),
        .busy(busy), .ready(ready), .power_mode(power_mode), .hold(hold),
        .ref_enable(ref_enable), .amp_enable(amp_enable), .result(result),
        .result_valid(result_valid));
    task automatic check(input logic [143:0] s, input logic [143:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d of %0d compares", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // wait out busy, then judge the end of conversion
    task automatic conv_end(input logic [143:0] v);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clock);
        check(blen, CONV);
        check(hold, 0);
        check(result, v);
        check(result_valid, 1);
    endtask
    // common start, then a refused start while busy
    task automatic t_tied(input logic [143:0] v);
        logic [143:0] old;
        old = result;
        blen = 0;
        core_sample = v;
        host.start(2'b11);
        @(negedge clock);
        check(hold, 8'hff);
        check(busy, 1);
        host.start(2'b11);
        check(result, old);
        conv_end(v);
    endtask
    // groups apart, the group started first pulsed twice
    task automatic t_split(input logic [1:0] a, input logic [143:0] v);
        blen = 0;
        core_sample = v;
        host.start(a);
        host.start(a);
        @(negedge clock);
        check(hold, a[0] ? 8'h0f : 8'hf0);
        check(busy, 0);
        host.start(~a);
        @(negedge clock);
        check(busy, 1);
        conv_end(v);
    endtask
    // power down, wake, and the reset that shutdown needs
    task automatic t_power(input logic r);
        host.power(0, r);
        repeat (3) @(negedge clock);
        check(power_mode, r ? ACP_PWR_STANDBY : ACP_PWR_SHUTDOWN);
        check({ref_enable, amp_enable}, {r, 1'b0});
        check(result_valid, r);
        // wake begun and dropped again: the timer must restart from full
        host.power(1, r);
        host.power(0, r);
        host.power(1, r);
        repeat (r ? 7 : 17) @(negedge clock);
        check(ready, 0);
        repeat (8) @(negedge clock);
        check(ready, r);
        rst = !r;
        @(negedge clock);
        rst = 0;
        repeat (3) @(negedge clock);
        check(ready, 1);
        check({ref_enable, amp_enable}, 2'b11);
    endtask
    initial begin
        repeat (16) @(negedge clock);
        rst = 0;
        repeat (3) @(negedge clock);
        t_tied({8{18'h2a5c3}});
        t_split(2'b01, {8{18'h1b0e4}});
        t_split(2'b10, {8{18'h3c71a}});
        t_power(1);
        t_tied({8{18'h05f2d}});
        t_power(0);
        t_tied({8{18'h3ffff}});
        report_and_stop;
    end
endmodule
bind acp_ctrl acp_ctrl_props #(.CONV_CYCLES(CONV_CYCLES), .CH(CH), .SW(SW)) u_props (
    .clock(clock), .rst(rst), .convert_start_group1(convert_start_group1),
    .convert_start_group2(convert_start_group2), .low_power_select_n(low_power_select_n),
    .range_select(range_select), .core_sample(core_sample), .busy(busy), .ready(ready),
    .power_mode(power_mode), .hold(hold), .ref_enable(ref_enable), .amp_enable(amp_enable),
    .result(result), .result_valid(result_valid));
`default_nettype wire
